// >>> include/bbd_params.svh
// constants for the byte/bit/literal instruction core
`ifndef BBD_PARAMS_SVH
`define BBD_PARAMS_SVH
`define BBD_CTRL_OFF 8'h00
`define BBD_STAT_OFF 8'h04
`define BBD_PC_OFF 8'h08
`define BBD_RESP_OKAY 2'b00
`define BBD_RESP_SLVERR 2'b10
`define BBD_CTRL_RUN 0
`define BBD_CTRL_WAKE 1
`define BBD_RST_TO 1'b1
`define BBD_RST_PD 1'b1
`define BBD_STACK_DEPTH 8
`define BBD_TIMER_ADDR 7'h01
`define BBD_PORT_LO 7'h05
`define BBD_PORT_HI 7'h09
`define BBD_GRP_BYTE 2'b00
`define BBD_GRP_BIT 2'b01
`define BBD_GRP_CTL 2'b10
`define BBD_GRP_LIT 2'b11
`define BBD_OP_MOVE_ACC 4'h0
`define BBD_OP_CLR 4'h1
`define BBD_OP_SUB 4'h2
`define BBD_OP_DEC 4'h3
`define BBD_OP_IOR 4'h4
`define BBD_OP_AND 4'h5
`define BBD_OP_XOR 4'h6
`define BBD_OP_ADD 4'h7
`define BBD_OP_MOVE_REG 4'h8
`define BBD_OP_COM 4'h9
`define BBD_OP_INC 4'hA
`define BBD_OP_DECSZ 4'hB
`define BBD_OP_RRC 4'hC
`define BBD_OP_RLC 4'hD
`define BBD_OP_SWAP 4'hE
`define BBD_OP_INCSZ 4'hF
`define BBD_LIT_NONE 4'hB
`define BBD_RETURN_WORD 14'h0008
`define BBD_IRET_WORD 14'h0009
`define BBD_SLEEP_WORD 14'h0063
`define BBD_WDCLR_WORD 14'h0064
`endif

// >>> include/bbd_pkg.sv
// types for the byte/bit/literal instruction core
`include "bbd_params.svh"
package bbd_pkg;
  typedef enum logic [1:0] {Q1, Q2, Q3, Q4} bbd_qph_e;
  typedef struct packed {
    bbd_qph_e qph;
    logic run, sleep, flush, global_interrupt_enable, c, dc, z, to, pd, c3, dc3;
    logic [10:0] pc;
    logic [13:0] ir;
    logic [7:0] w, opnd, res, pinMeta, pinSync;
    logic [2:0] sp;
    logic [`BBD_STACK_DEPTH-1:0][10:0] stk;
    logic awGot, wGot, wStrb0, bvalid, rvalid;
    logic [7:0] awAddr;
    logic [31:0] wData, rdata;
    logic [1:0] bresp, rresp;
  } bbd_state_s;
endpackage : bbd_pkg

// >>> hw/bbd_core.sv
// instruction decode and execution core with AXI4-Lite control registers
`timescale 1ns/10ps
`include "bbd_params.svh"
// Behaviour
// RULE1: one cycle per instruction; taken skip or pc change costs a second, no-op cycle
// RULE2: each instruction cycle is four oscillator periods
// RULE3: destination bit zero writes accumulator, one writes the file register
// RULE4: rotate left/right through carry change only carry
// RULE5: decrement/increment with skip on zero, no flags touched
// RULE6: xor, or, and of accumulator with register change only zero
// RULE7: bit words give set and clear of one selected bit, no flags
// RULE8: bit test skips next instruction when tested bit is clear
// RULE9: bit test skips next instruction when tested bit is set
// RULE10: call and jump load eleven-bit literal into pc; call pushes return address
// RULE11: return, interrupt return and literal return pop the stack in two cycles
// RULE12: standby and watchdog clear update timeout and power-down bits
// RULE13: literal add, subtract, or, and, xor and move on the accumulator
// RULE14: don't-care bits never change how a word decodes
// RULE15: a port register used as source reads the pin levels
// RULE16: writing the timer-zero register clears a prescaler assigned to it
// RULE17: remaining byte operations follow the table, most updating zero
// RULE18: decode, read, process and write fall in quarters one to four
module bbd_core (
  input wire logic clk, // core oscillator, 40 MHz
  input wire logic rst, // asynchronous reset, active high
  input wire logic [7:0] s_axi_awaddr, // write address
  input wire logic s_axi_awvalid, // write address valid
  output logic s_axi_awready, // write address ready
  input wire logic [31:0] s_axi_wdata, // write data
  input wire logic [3:0] s_axi_wstrb, // write strobes
  input wire logic s_axi_wvalid, // write data valid
  output logic s_axi_wready, // write data ready
  output logic [1:0] s_axi_bresp, // write response
  output logic s_axi_bvalid, // write response valid
  input wire logic s_axi_bready, // write response ready
  input wire logic [7:0] s_axi_araddr, // read address
  input wire logic s_axi_arvalid, // read address valid
  output logic s_axi_arready, // read address ready
  output logic [31:0] s_axi_rdata, // read data
  output logic [1:0] s_axi_rresp, // read response
  output logic s_axi_rvalid, // read data valid
  input wire logic s_axi_rready, // read data ready
  output logic [10:0] pmAddr, // program memory word address
  input wire logic [13:0] pmData, // instruction word at pmAddr
  output logic [6:0] fileAddr, // data file register address
  input wire logic [7:0] fileRdData, // file register latch value
  output logic [7:0] fileWrData, // file register write value
  output logic fileWe, // file register write strobe
  input wire logic [7:0] portPins, // pin levels of addressed port, async
  input wire logic prescToTimer0, // prescaler assigned to timer zero
  output logic prescClr, // prescaler clear strobe
  output logic wdtClr, // watchdog clear strobe
  output logic sleeping // core in standby
);
  bbd_pkg::bbd_state_s s;
  bbd_pkg::bbd_state_s n;
  logic [1:0] grp;
  logic [3:0] op;
  logic [3:0] aluOp;
  logic [2:0] bIdx;
  logic [7:0] k8;
  logic [10:0] kAddr;
  logic [7:0] src;
  logic [7:0] aluA;
  logic [7:0] aluRes;
  logic aluC;
  logic aluDC;
  logic [8:0] sum9;
  logic [4:0] sum5;
  logic isPort;
  logic exe;
  logic wrFile;
  logic wrW;
  logic updC;
  logic updDC;
  logic updZ;
  logic skipZ;
  logic bitTest;
  logic skipTaken;
  logic jump;
  logic call;
  logic pop;
  logic retie;
  logic goSleep;
  logic clrWd;
  logic atQ4;

  always_comb begin
    n = s;
    grp = s.ir[13:12];
    op = s.ir[11:8];
    bIdx = s.ir[9:7];
    k8 = s.ir[7:0];
    kAddr = s.ir[10:0];
    atQ4 = s.qph == bbd_pkg::Q4;
    exe = s.run & ~s.sleep & ~s.flush; // RULE1
    // port reads take the pin levels; they are synchronised from Q1, so used in Q3
    isPort = s.ir[6:0] >= `BBD_PORT_LO && s.ir[6:0] <= `BBD_PORT_HI;
    src = isPort ? s.pinSync : s.opnd; // RULE15
    // decode; x positions are never compared so either value decodes alike
    wrFile = 1'b0; // RULE14
    wrW = 1'b0;
    updC = 1'b0;
    updDC = 1'b0;
    updZ = 1'b0;
    skipZ = 1'b0;
    bitTest = 1'b0;
    jump = 1'b0;
    call = 1'b0;
    pop = 1'b0;
    retie = 1'b0;
    goSleep = 1'b0;
    clrWd = 1'b0;
    aluOp = op;
    unique case (grp)
      `BBD_GRP_BYTE: begin
        wrFile = s.ir[7]; // RULE3
        wrW = ~s.ir[7] && op != `BBD_OP_MOVE_ACC;
        updZ = !(op inside {`BBD_OP_MOVE_ACC, `BBD_OP_DECSZ, `BBD_OP_INCSZ, `BBD_OP_RRC, `BBD_OP_RLC,
                 `BBD_OP_SWAP}); // RULE6 RULE17
        updC = op inside {`BBD_OP_SUB, `BBD_OP_ADD, `BBD_OP_RRC, `BBD_OP_RLC}; // RULE4
        updDC = op inside {`BBD_OP_SUB, `BBD_OP_ADD};
        skipZ = op inside {`BBD_OP_DECSZ, `BBD_OP_INCSZ}; // RULE5
        pop = s.ir == `BBD_RETURN_WORD || s.ir == `BBD_IRET_WORD; // RULE11
        retie = s.ir == `BBD_IRET_WORD;
        goSleep = s.ir == `BBD_SLEEP_WORD; // RULE12
        clrWd = s.ir == `BBD_WDCLR_WORD;
      end
      `BBD_GRP_BIT: begin
        wrFile = ~s.ir[11]; // RULE7
        bitTest = s.ir[11]; // RULE8 RULE9
        // opcode bits here hold the bit index, so the alu must pass the operand through
        aluOp = `BBD_OP_MOVE_REG;
      end
      `BBD_GRP_CTL: begin
        jump = 1'b1; // RULE10
        call = ~s.ir[11];
      end
      `BBD_GRP_LIT: begin
        wrW = op != `BBD_LIT_NONE; // RULE13
        updZ = op[3] && op != `BBD_LIT_NONE;
        updC = op[3:2] == 2'b11;
        updDC = op[3:2] == 2'b11;
        pop = op[3:2] == 2'b01; // RULE11
        unique case (op[3:2])
          2'b00, 2'b01: aluOp = `BBD_OP_MOVE_REG;
          2'b10: aluOp = (op[1:0] == 2'b00) ? `BBD_OP_IOR : (op[1:0] == 2'b01) ? `BBD_OP_AND :
                         (op[1:0] == 2'b10) ? `BBD_OP_XOR : `BBD_OP_MOVE_ACC;
          2'b11: aluOp = op[1] ? `BBD_OP_ADD : `BBD_OP_SUB;
        endcase
      end
    endcase
    // process
    aluA = (grp == `BBD_GRP_LIT) ? k8 : src;
    aluC = s.c;
    aluDC = s.dc;
    sum9 = {1'b0, aluA} + {1'b0, s.w};
    sum5 = {1'b0, aluA[3:0]} + {1'b0, s.w[3:0]};
    if (aluOp == `BBD_OP_SUB) begin
      sum9 = {1'b0, aluA} + {1'b0, ~s.w} + 9'h001;
      sum5 = {1'b0, aluA[3:0]} + {1'b0, ~s.w[3:0]} + 5'h01;
    end
    aluRes = aluA;
    unique case (aluOp)
      `BBD_OP_MOVE_ACC: aluRes = s.w;
      `BBD_OP_CLR: aluRes = 8'h00;
      `BBD_OP_SUB, `BBD_OP_ADD: begin
        aluRes = sum9[7:0]; // RULE13
        aluC = sum9[8];
        aluDC = sum5[4];
      end
      `BBD_OP_DEC, `BBD_OP_DECSZ: aluRes = aluA - 8'h01;
      `BBD_OP_IOR: aluRes = aluA | s.w; // RULE6
      `BBD_OP_AND: aluRes = aluA & s.w;
      `BBD_OP_XOR: aluRes = aluA ^ s.w;
      `BBD_OP_MOVE_REG: aluRes = aluA;
      `BBD_OP_COM: aluRes = ~aluA;
      `BBD_OP_INC, `BBD_OP_INCSZ: aluRes = aluA + 8'h01;
      `BBD_OP_RRC: begin
        aluRes = {s.c, aluA[7:1]}; // RULE4
        aluC = aluA[0];
      end
      `BBD_OP_RLC: begin
        aluRes = {aluA[6:0], s.c};
        aluC = aluA[7];
      end
      `BBD_OP_SWAP: aluRes = {aluA[3:0], aluA[7:4]};
    endcase
    if (grp == `BBD_GRP_BIT && !s.ir[11]) begin
      aluRes[bIdx] = s.ir[10]; // RULE7
    end
    skipTaken = (skipZ && s.res == 8'h00) || (bitTest && s.res[bIdx] == s.ir[10]); // RULE5 RULE8 RULE9
    // pin synchroniser
    n.pinMeta = portPins;
    n.pinSync = s.pinMeta;
    // register bus, write channel; both halves may arrive in either order
    if (s_axi_awvalid && !s.awGot) begin
      n.awGot = 1'b1;
      n.awAddr = s_axi_awaddr;
    end
    if (s_axi_wvalid && !s.wGot) begin
      n.wGot = 1'b1;
      n.wData = s_axi_wdata;
      n.wStrb0 = s_axi_wstrb[0];
    end
    if (s.bvalid && s_axi_bready) begin
      n.bvalid = 1'b0;
    end
    if (s.awGot && s.wGot && !s.bvalid) begin
      n.awGot = 1'b0;
      n.wGot = 1'b0;
      n.bvalid = 1'b1;
      n.bresp = `BBD_RESP_SLVERR;
      if (s.awAddr[7:2] == `BBD_CTRL_OFF >> 2) begin
        n.bresp = `BBD_RESP_OKAY;
        if (s.wStrb0) begin
          n.run = s.wData[`BBD_CTRL_RUN];
          if (s.wData[`BBD_CTRL_WAKE]) begin
            n.sleep = 1'b0;
          end
        end
      end else if (s.awAddr[7:2] == `BBD_STAT_OFF >> 2 || s.awAddr[7:2] == `BBD_PC_OFF >> 2) begin
        n.bresp = `BBD_RESP_OKAY;
      end
    end
    // register bus, read channel
    if (s.rvalid && s_axi_rready) begin
      n.rvalid = 1'b0;
    end
    if (s_axi_arvalid && !s.rvalid) begin
      n.rvalid = 1'b1;
      n.rresp = `BBD_RESP_OKAY;
      n.rdata = 32'h0000_0000;
      unique case (s_axi_araddr[7:2])
        `BBD_CTRL_OFF >> 2: n.rdata[`BBD_CTRL_RUN] = s.run;
        `BBD_STAT_OFF >> 2: n.rdata = {17'h0_0000, s.global_interrupt_enable, s.to, s.pd, s.sleep, s.c, s.dc, s.z, s.w};
        `BBD_PC_OFF >> 2: n.rdata = {21'h00_0000, s.pc};
        default: n.rresp = `BBD_RESP_SLVERR;
      endcase
    end
    // quarter sequencer
    unique case (s.qph)
      bbd_pkg::Q1: n.qph = bbd_pkg::Q2; // RULE2
      bbd_pkg::Q2: begin
        n.qph = bbd_pkg::Q3;
        n.opnd = fileRdData; // RULE18
      end
      bbd_pkg::Q3: begin
        n.qph = bbd_pkg::Q4;
        n.res = aluRes; // RULE18
        n.c3 = aluC;
        n.dc3 = aluDC;
      end
      bbd_pkg::Q4: begin
        n.qph = bbd_pkg::Q1;
        if (s.run && !s.sleep) begin
          // fetch overlaps execute; a discarded fetch becomes the no-op cycle
          n.ir = pmData;
          n.pc = s.pc + 11'h001;
          n.flush = 1'b0;
          if (exe) begin
            if (wrW) begin
              n.w = s.res; // RULE3
            end
            if (updC) begin
              n.c = s.c3;
            end
            if (updDC) begin
              n.dc = s.dc3;
            end
            if (updZ) begin
              n.z = s.res == 8'h00;
            end
            n.flush = skipTaken || jump || pop; // RULE1
            if (jump) begin
              n.pc = kAddr; // RULE10
            end
            if (call) begin
              n.stk[s.sp] = s.pc; // RULE10
              n.sp = s.sp + 3'h1;
            end
            if (pop) begin
              n.pc = s.stk[s.sp - 3'h1]; // RULE11
              n.sp = s.sp - 3'h1;
            end
            if (retie) begin
              n.global_interrupt_enable = 1'b1;
            end
            if (goSleep) begin
              n.sleep = 1'b1; // RULE12
              n.to = 1'b1;
              n.pd = 1'b0;
            end
            if (clrWd) begin
              n.to = 1'b1; // RULE12
              n.pd = 1'b1;
            end
          end
        end
      end
    endcase
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      s <= '0;
      s.to <= `BBD_RST_TO;
      s.pd <= `BBD_RST_PD;
    end else begin
      s <= n;
    end
  end

  assign s_axi_awready = ~s.awGot;
  assign s_axi_wready = ~s.wGot;
  assign s_axi_bvalid = s.bvalid;
  assign s_axi_bresp = s.bresp;
  assign s_axi_arready = ~s.rvalid;
  assign s_axi_rvalid = s.rvalid;
  assign s_axi_rdata = s.rdata;
  assign s_axi_rresp = s.rresp;
  assign pmAddr = s.pc;
  assign fileAddr = s.ir[6:0];
  assign fileWrData = s.res;
  assign fileWe = atQ4 & exe & wrFile; // RULE3 RULE18
  assign prescClr = fileWe && s.ir[6:0] == `BBD_TIMER_ADDR && prescToTimer0; // RULE16
  assign wdtClr = atQ4 & exe & clrWd; // RULE12
  assign sleeping = s.sleep;

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  sequence seqRestOfCycle;
    s.qph == bbd_pkg::Q2 ##1 s.qph == bbd_pkg::Q3 ##1 s.qph == bbd_pkg::Q4 ##1 s.qph == bbd_pkg::Q1;
  endsequence
  sequence seqFlushedCycle;
    (s.flush && !fileWe) [*4];
  endsequence

  chk_quarter_order: assert property (s.qph == bbd_pkg::Q1 |=> seqRestOfCycle) // RULE2
    else $error("quarters out of order");
  chk_write_quarter: assert property (fileWe |-> s.qph == bbd_pkg::Q4) // RULE18
    else $error("file write outside fourth quarter");
  chk_dest_acc: assert property (atQ4 && exe && grp == `BBD_GRP_BYTE && !s.ir[7] |-> !fileWe) // RULE3
    else $error("accumulator destination wrote the file");
  chk_skip_noop: assert property (atQ4 && exe && skipTaken && s.run && !s.sleep |=> seqFlushedCycle) // RULE8
    else $error("skipped instruction was not a no-op cycle");
  chk_jump_target: assert property (atQ4 && exe && jump |=> s.pc == $past(kAddr) && s.flush) // RULE10
    else $error("jump did not load its literal");
  chk_call_push: assert property (atQ4 && exe && call |=> s.sp == $past(s.sp) + 3'h1) // RULE10
    else $error("call did not push");
  chk_prescaler_clear: assert property (prescClr |-> fileWe && fileAddr == `BBD_TIMER_ADDR) // RULE16
    else $error("prescaler clear without timer write");
  chk_standby_bits: assert property (atQ4 && exe && goSleep |=> s.sleep && s.to && !s.pd) // RULE12
    else $error("standby bits wrong");
  chk_rotate_zero: assert property (atQ4 && exe && aluOp inside {`BBD_OP_RRC, `BBD_OP_RLC}
    && grp == `BBD_GRP_BYTE |=> s.z == $past(s.z) && s.dc == $past(s.dc)) // RULE4
    else $error("rotate touched other flags");
endmodule : bbd_core

// >>> testbench/bbd_far_model.sv
// program memory and data file registers seen by the core
`timescale 1ns/10ps
module bbd_far_model (
  input wire logic clk, // core clock
  input wire logic [10:0] pmAddr, // fetch address
  output logic [13:0] pmData, // word at fetch address
  input wire logic [6:0] fileAddr, // file register address
  output logic [7:0] fileRdData, // latch value
  input wire logic [7:0] fileWrData, // write value
  input wire logic fileWe // write strobe
);
  logic [13:0] pm [0:63];
  logic [7:0] rf [0:127];
  // memory is only 64 words deep; the bench programs stay below that
  assign pmData = pm[pmAddr[5:0]];
  assign fileRdData = rf[fileAddr];
  always @(posedge clk) begin
    if (fileWe === 1'b1) rf[fileAddr] <= fileWrData;
  end
endmodule : bbd_far_model

// >>> testbench/tb_top.sv
// self-checking bench: random programs against an instruction model
`timescale 1ns/10ps
`include "bbd_params.svh"
module tb_top;
  localparam int N = 40;
  logic clk = 1'b0, rst = 1'b1, presc = 1'b0, counting = 1'b0, aV = 1'b0, wV = 1'b0, bR = 1'b0, arV = 1'b0, rR = 1'b0;
  logic [7:0] aA = 8'h00, arA = 8'h00, pins = 8'h00, mW, mf [0:127];
  logic [31:0] wD = 32'h0000_0000, rDut, seed = 32'h0001_39E5, dat;
  logic [1:0] bResp, rResp, resp;
  logic aRdy, wRdy, bV, arRdy, rV, fileWe, prescClr, wdtClr, sleeping, mC, mDC, mZ, mTo, mPd, mSlp;
  logic [10:0] pmAddr, lastPm = 11'h000;
  logic [13:0] pmData, prog [0:63];
  logic [6:0] fileAddr;
  logic [7:0] fileRdData, fileWrData;
  logic [10:0] stk [$];
  int pcM, cyc, nPresc, nWdt, nPc, nWd, nChg, sinceChg = 0, cycCnt = 0, nFail = 0, samplesChecked = 0;
  bbd_core uut (.clk(clk), .rst(rst), .s_axi_awaddr(aA), .s_axi_awvalid(aV), .s_axi_awready(aRdy),
    .s_axi_wdata(wD), .s_axi_wstrb(4'hF), .s_axi_wvalid(wV), .s_axi_wready(wRdy), .s_axi_bresp(bResp),
    .s_axi_bvalid(bV), .s_axi_bready(bR), .s_axi_araddr(arA), .s_axi_arvalid(arV), .s_axi_arready(arRdy),
    .s_axi_rdata(rDut), .s_axi_rresp(rResp), .s_axi_rvalid(rV), .s_axi_rready(rR), .pmAddr(pmAddr),
    .pmData(pmData), .fileAddr(fileAddr), .fileRdData(fileRdData), .fileWrData(fileWrData), .fileWe(fileWe),
    .portPins(pins), .prescToTimer0(presc), .prescClr(prescClr), .wdtClr(wdtClr), .sleeping(sleeping));
  bbd_far_model mem (.clk(clk), .pmAddr(pmAddr), .pmData(pmData), .fileAddr(fileAddr),
    .fileRdData(fileRdData), .fileWrData(fileWrData), .fileWe(fileWe));
  always #12.5 clk = ~clk;
  function logic [31:0] rnd();
    repeat (8) seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
    return seed;
  endfunction : rnd
  task tallyAndFinish;
    $display("checked %0d, failed %0d", samplesChecked, nFail);
    if (nFail == 0 && samplesChecked > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : tallyAndFinish
  task chk(input logic [31:0] got, input logic [31:0] exp);
    samplesChecked++;
    if (got !== exp) begin
      nFail++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  // handshakes are judged at the rising edge, on the values that stood before it
  task axi_wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    logic hb;
    @(posedge clk);
    aA <= a; wD <= d; aV <= 1'b1; wV <= 1'b1; bR <= 1'b1;
    do begin
      @(posedge clk);
      if (aV && aRdy) aV <= 1'b0;
      if (wV && wRdy) wV <= 1'b0;
      hb = bV; r = bResp;
    end while (hb !== 1'b1);
    bR <= 1'b0;
  endtask : axi_wr
  task axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    logic hv;
    @(posedge clk);
    arA <= a; arV <= 1'b1; rR <= 1'b1;
    do begin
      @(posedge clk);
      if (arV && arRdy) arV <= 1'b0;
      hv = rV; d = rDut; r = rResp;
    end while (hv !== 1'b1);
    rR <= 1'b0;
  endtask : axi_rd
  task wrf(input int f, input logic [7:0] r);
    mf[f] = r;
    if (f == 1 && presc) nPresc++;
  endtask : wrf
  task step;
    logic [13:0] iw; logic [7:0] k, opd, r; logic [3:0] op; logic [6:0] f; logic sk;
    iw = prog[pcM]; k = iw[7:0]; f = iw[6:0]; op = iw[11:8]; sk = 1'b0; r = mW;
    opd = (f >= 7'h05 && f <= 7'h09) ? pins : mf[f];
    pcM++;
    cyc++;
    if (iw == `BBD_SLEEP_WORD) begin mTo = 1'b1; mPd = 1'b0; mSlp = 1'b1; end
    else if (iw == `BBD_WDCLR_WORD) begin mTo = 1'b1; mPd = 1'b1; nWdt++; end
    else if (iw[13:12] == 2'b00) begin
      case (op)
        4'h0: r = mW;
        4'h1: r = 8'h00;
        4'h2: r = opd - mW;
        4'h3, 4'hB: r = opd - 8'h01;
        4'h4: r = opd | mW;
        4'h5: r = opd & mW;
        4'h6: r = opd ^ mW;
        4'h7: r = opd + mW;
        4'h8: r = opd;
        4'h9: r = ~opd;
        4'hA, 4'hF: r = opd + 8'h01;
        4'hC: r = {mC, opd[7:1]};
        4'hD: r = {opd[6:0], mC};
        default: r = {opd[3:0], opd[7:4]};
      endcase
      if (op == 4'h2) begin mC = opd >= mW; mDC = opd[3:0] >= mW[3:0]; end
      if (op == 4'h7) begin mC = opd + mW > 255; mDC = opd[3:0] + mW[3:0] > 15; end
      if (op == 4'hC || op == 4'hD) mC = op[0] ? opd[7] : opd[0];
      if (op != 4'h0 && op < 4'hB) mZ = (r == 8'h00);
      sk = (op == 4'hB || op == 4'hF) && r == 8'h00;
      if (iw[7]) wrf(f, r);
      else if (op != 4'h0) mW = r;
    end else if (iw[13:12] == 2'b01) begin
      if (!iw[11]) begin r = opd; r[iw[9:7]] = iw[10]; wrf(f, r); end
      else sk = (opd[iw[9:7]] == iw[10]);
    end else if (iw[13:12] == 2'b10) begin
      if (!iw[11]) stk.push_back(11'(pcM));
      pcM = iw[10:0];
      cyc++;
    end else begin
      case (op)
        4'h8: mW = k | mW;
        4'h9: mW = k & mW;
        4'hA: mW = k ^ mW;
        4'hC, 4'hD: begin mC = k >= mW; mDC = k[3:0] >= mW[3:0]; mW = k - mW; end
        4'hE, 4'hF: begin mC = k + mW > 255; mDC = k[3:0] + mW[3:0] > 15; mW = k + mW; end
        4'h4, 4'h5, 4'h6, 4'h7: begin mW = k; pcM = stk.pop_back(); cyc++; end
        4'hB: ;
        default: mW = k;
      endcase
      if (op[3] && op != 4'hB) mZ = (mW == 8'h00);
    end
    if (sk) begin pcM++; cyc++; end
  endtask : step
  task gen;
    logic [31:0] r; logic [3:0] op; logic [6:0] f;
    for (int i = 0; i < 64; i++) prog[i] = 14'h0000;
    r = rnd();
    prog[0] = 14'h2802;
    prog[1] = {4'b1101, r[1:0], r[15:8]};
    prog[2] = 14'h2001;
    for (int i = 3; i < N - 2; i++) begin
      r = rnd();
      f = (r[11:8] < 4'd8) ? 7'h20 + 7'(r[10:8]) : (r[8] ? 7'h01 : 7'h05);
      op = r[15:12];
      case (r[17:16])
        2'b00: prog[i] = {2'b00, op, r[18] | (op == 4'h0), f};
        2'b01: prog[i] = {2'b01, r[19:18], r[22:20], f};
        2'b10: prog[i] = r[23] ? `BBD_WDCLR_WORD : {2'b00, op, 1'b1, f};
        default: prog[i] = {2'b11, (op[3:2] == 2'b01 || op == 4'hB) ? 4'h0 : op, r[31:24]};
      endcase
    end
    prog[N - 2] = {4'b1100, r[25:24], r[7:0]};
    prog[N - 1] = `BBD_SLEEP_WORD;
    prog[N] = `BBD_WDCLR_WORD;
    prog[N + 1] = {3'b101, 11'(N + 1)};
    for (int i = 0; i < 64; i++) mem.pm[i] = prog[i];
    for (int i = 0; i < 128; i++) begin mf[i] = rnd(); mem.rf[i] = mf[i]; end
  endtask : gen
  always @(posedge clk) begin
    cycCnt++;
    if (cycCnt == 6000) begin nFail++; tallyAndFinish; end
  end
  always @(negedge clk) begin
    sinceChg++;
    if (prescClr === 1'b1) nPc++;
    if (wdtClr === 1'b1) nWd++;
    if (pmAddr !== lastPm) begin
      if (counting) begin
        if (nChg > 0) chk(sinceChg, 4);
        nChg++;
        if (pmAddr == N) counting = 1'b0;
      end
      lastPm = pmAddr;
      sinceChg = 0;
    end
  end
  initial begin
    for (int round = 0; round < 2; round++) begin
      rst <= 1'b1;
      repeat (20) @(posedge clk);
      presc <= round[0];
      gen;
      pins <= mf[100] ^ 8'hA5;
      mW = 8'h00; mC = 1'b0; mDC = 1'b0; mZ = 1'b0; mTo = 1'b1; mPd = 1'b1; mSlp = 1'b0;
      stk.delete();
      pcM = 0; cyc = 0; nPresc = 0; nWdt = 0; nPc = 0; nWd = 0; nChg = 0;
      rst <= 1'b0;
      @(posedge clk);
      counting = 1'b1;
      axi_wr(`BBD_CTRL_OFF, 32'h0000_0001, resp);
      chk(resp, `BBD_RESP_OKAY);
      while (pcM != N - 1) step;
      while (counting) @(negedge clk);
      chk(nChg, cyc + 1);
      step;
      while (sleeping !== 1'b1) @(negedge clk);
      axi_rd(`BBD_STAT_OFF, dat, resp);
      chk(dat, {18'h0_0000, mTo, mPd, mSlp, mC, mDC, mZ, mW});
      axi_wr(`BBD_CTRL_OFF, 32'h0000_0003, resp);
      mSlp = 1'b0;
      step;
      while (pmAddr !== N + 2) @(negedge clk);
      axi_rd(`BBD_STAT_OFF, dat, resp);
      chk(dat, {18'h0_0000, mTo, mPd, mSlp, mC, mDC, mZ, mW});
      chk(nWd, nWdt);
      chk(nPc, nPresc);
      for (int f = 0; f < 10; f++) chk(mem.rf[f < 8 ? 32 + f : f - 7], mf[f < 8 ? 32 + f : f - 7]);
      axi_rd(`BBD_CTRL_OFF, dat, resp);
      chk(dat, 32'h0000_0001);
      axi_rd(8'h0C, dat, resp);
      chk({dat[29:0], resp}, {30'h0000_0000, `BBD_RESP_SLVERR});
      axi_wr(8'h10, 32'h0000_0001, resp);
      chk(resp, `BBD_RESP_SLVERR);
    end
    tallyAndFinish;
  end
endmodule : tb_top
